// ==== logic/serial_unit_pkg.sv ====
// Purpose: constants shared by the two-wire serial unit
// Assumes: system clock 20 MHz, link sampling clock 8 MHz
// Notes:   mode and clock-source encodings of the unit's control bits
`default_nettype none
package serial_unit_pkg;
    // clock rates
    localparam int unsigned SYS_CLK_HZ         = 20_000_000;
    localparam int unsigned LINK_CLK_HZ        = 8_000_000;
    localparam int unsigned LINK_PERIOD_NS     = 1_000_000_000 / LINK_CLK_HZ;
    // sda delay ahead of the start detector
    localparam int unsigned SDA_DELAY_MIN_NS   = 50;
    localparam int unsigned SDA_DELAY_MAX_NS   = 300;
    localparam int unsigned SDA_DELAY_CYC_RAW  = (SDA_DELAY_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int unsigned SDA_DELAY_CYC      = (SDA_DELAY_CYC_RAW < 1) ? 1 : SDA_DELAY_CYC_RAW;
    // wire mode field
    localparam logic [1:0] WIRE_NONE           = 2'h0;
    localparam logic [1:0] WIRE_THREE          = 2'h1;
    localparam logic [1:0] WIRE_TWO            = 2'h2;
    localparam logic [1:0] WIRE_TWO_OVF_HOLD   = 2'h3;
    localparam int unsigned WIRE_MODE_LOW_BIT  = 0;
    // clock source field
    localparam logic [1:0] CLK_SRC_STROBE      = 2'h0;
    localparam logic [1:0] CLK_SRC_TIMER0      = 2'h1;
    localparam logic [1:0] CLK_SRC_EXT_POS     = 2'h2;
    localparam logic [1:0] CLK_SRC_EXT_NEG     = 2'h3;
    localparam int unsigned EXT_SRC_BIT        = 1;
    localparam int unsigned EDGE_SEL_BIT       = 0;
    // widths and reset values
    localparam int unsigned DATA_W             = 8;
    localparam int unsigned COUNT_W            = 4;
    localparam int unsigned MSB_POS            = 7;
    localparam logic [7:0] SHIFT_RESET         = 8'h00;
    localparam logic [3:0] COUNT_RESET         = 4'h0;
    localparam logic [3:0] COUNT_MAX           = 4'hf;
    localparam logic [3:0] COUNT_ONE           = 4'h1;
    // link state of the start/stop detector
    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_BUSY  = 3'b010,
        BUS_START = 3'b100
    } bus_state_t;
endpackage
`default_nettype wire

// ==== logic/universal_serial_unit.sv ====
// Purpose: two-wire / three-wire serial unit with 4-bit counter and start detector
// Assumes: pins sampled on link_clk_i, software side on clk_i
// Notes:   open-drain pins split into input, output and output enable
//
// Behaviour
// - two-wire physical layer, no filtering or slew
// - master clocks; only slave stretches scl
// - software toggles scl; hardware shifts on edges
// - two-wire uses negative-edge shift setting
// - slave inserts wait states holding scl low
// - every scl edge increments the counter
// - start detector sets start flag
// - hold scl after start until flag cleared
// - slave samples sda on scl rising edge
// - overflow after eight bits holds scl low
// - addressed slave acks, counter preset fourteen
// - direction bit chooses which side drives sda
// - bytes repeat until stop or new start
// - full receiver withholds last acknowledge
// - sda delayed before start detector samples scl
// - start detector independent of system clock
// - standalone counter, external both edges count
// - timer0 overflows clock counter: twelve bits
// - preset F plus external edge overflows
// - start flag cleared by one, releases hold
// - overflow on 15 to 0, clear releases hold
// - stop flag set on stop, write-one clear
`default_nettype none
module universal_serial_unit
    import serial_unit_pkg::*;
#(
    parameter int unsigned SDA_DELAY = SDA_DELAY_CYC
) (
    input  wire logic               clk_i,
    input  wire logic               rstn_i,
    input  wire logic               link_clk_i,
    input  wire logic [1:0]         wire_mode_i,
    input  wire logic [1:0]         clock_source_i,
    input  wire logic               clock_strobe_i,
    input  wire logic               toggle_strobe_i,
    input  wire logic               timer0_overflow_i,
    input  wire logic               shift_write_i,
    input  wire logic [DATA_W-1:0]  shift_wdata_i,
    input  wire logic               count_write_i,
    input  wire logic [COUNT_W-1:0] count_wdata_i,
    input  wire logic               clear_start_i,
    input  wire logic               clear_overflow_i,
    input  wire logic               clear_stop_i,
    input  wire logic               scl_dir_i,
    input  wire logic               sda_dir_i,
    input  wire logic               sda_port_i,
    input  wire logic               scl_port_write_i,
    input  wire logic               scl_port_wdata_i,
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    output logic [DATA_W-1:0]       shift_data_o,
    output logic [COUNT_W-1:0]      count_o,
    output logic                    start_detect_flag_o,
    output logic                    overflow_flag_o,
    output logic                    stop_detect_flag_o,
    output logic                    collision_o,
    output logic                    scl_o,
    output logic                    scl_oe_o,
    output logic                    sda_o,
    output logic                    sda_oe_o
);

    // ------------------------------------------------------------ link side
    logic                 scl_meta;
    logic                 scl_sync;
    logic                 scl_prev;
    logic                 sda_meta;
    logic                 sda_sync;
    logic [SDA_DELAY:0]   sda_dly;
    logic                 edge_bit;
    logic                 rise_tgl;
    logic                 fall_tgl;
    logic                 start_tgl;
    logic                 stop_tgl;
    bus_state_t           bus_state;
    bus_state_t           next_bus_state;

    wire scl_rise_l  = scl_sync & ~scl_prev;
    wire scl_fall_l  = ~scl_sync & scl_prev;
    wire sda_late    = sda_dly[SDA_DELAY];
    wire sda_early   = sda_dly[SDA_DELAY-1];
    // sda seen late so scl is already settled when sda moves
    wire start_cond  = scl_sync & sda_late & ~sda_early;
    wire stop_cond   = scl_sync & ~sda_late & sda_early;

    // no glitch filter on the pins, only the two sampling flops
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            scl_meta <= scl_i;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_i;
            sda_sync <= sda_meta;
        end
    end

    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sda_dly <= '1;
        end else begin
            sda_dly <= {sda_dly[SDA_DELAY-1:0], sda_sync};
        end
    end

    // sda value at each scl edge, stable until the next edge
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            edge_bit <= 1'b1;
        end else if (scl_rise_l || scl_fall_l) begin
            edge_bit <= sda_sync;
        end
    end

    // events leave the link domain as toggles
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rise_tgl  <= 1'b0;
            fall_tgl  <= 1'b0;
            start_tgl <= 1'b0;
            stop_tgl  <= 1'b0;
        end else begin
            rise_tgl  <= rise_tgl ^ scl_rise_l;
            fall_tgl  <= fall_tgl ^ scl_fall_l;
            start_tgl <= start_tgl ^ (next_bus_state == BUS_START);
            stop_tgl  <= stop_tgl ^ stop_cond;
        end
    end

    // start detection needs only the link clock, not clk_i
    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            BUS_IDLE:  if (start_cond) next_bus_state = BUS_START;
            BUS_START: next_bus_state = stop_cond ? BUS_IDLE : BUS_BUSY;
            BUS_BUSY: begin
                if (stop_cond) begin
                    next_bus_state = BUS_IDLE;
                end else if (start_cond) begin
                    next_bus_state = BUS_START;
                end
            end
            default:   next_bus_state = BUS_IDLE;
        endcase
    end

    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_state <= BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    // ---------------------------------------------------------- system side
    logic [3:0]           evt_meta;
    logic [3:0]           evt_sync;
    logic [3:0]           evt_prev;
    logic                 bit_meta;
    logic                 bit_sync;
    logic                 pin_scl_meta;
    logic                 pin_scl;
    logic                 pin_sda_meta;
    logic                 pin_sda;
    logic [DATA_W-1:0]    shift_reg;
    logic [COUNT_W-1:0]   count;
    logic                 start_flag;
    logic                 ovf_flag;
    logic                 stop_flag;
    logic                 out_latch;
    logic                 scl_port;
    logic                 start_hold;
    logic                 ovf_hold;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            evt_meta     <= 4'h0;
            evt_sync     <= 4'h0;
            evt_prev     <= 4'h0;
            bit_meta     <= 1'b1;
            bit_sync     <= 1'b1;
            pin_scl_meta <= 1'b1;
            pin_scl      <= 1'b1;
            pin_sda_meta <= 1'b1;
            pin_sda      <= 1'b1;
        end else begin
            evt_meta     <= {stop_tgl, start_tgl, fall_tgl, rise_tgl};
            evt_sync     <= evt_meta;
            evt_prev     <= evt_sync;
            bit_meta     <= edge_bit;
            bit_sync     <= bit_meta;
            pin_scl_meta <= scl_i;
            pin_scl      <= pin_scl_meta;
            pin_sda_meta <= sda_i;
            pin_sda      <= pin_sda_meta;
        end
    end

    wire [3:0] evt      = evt_sync ^ evt_prev;
    wire ev_rise        = evt[0];
    wire ev_fall        = evt[1];
    wire ev_start       = evt[2];
    wire ev_stop        = evt[3];

    wire ext_src        = clock_source_i[EXT_SRC_BIT];
    wire neg_edge_mode  = clock_source_i[EDGE_SEL_BIT];
    wire two_wire       = wire_mode_i[1];
    wire ovf_hold_mode  = (wire_mode_i == WIRE_TWO_OVF_HOLD);

    // every scl edge counts; sampling edge follows the edge select
    wire ext_count_tick = ext_src & (ev_rise | ev_fall);
    wire ext_shift_tick = ext_src & (neg_edge_mode ? ev_rise : ev_fall);
    wire count_tick     = (clock_source_i == CLK_SRC_STROBE) ? clock_strobe_i :
                          (clock_source_i == CLK_SRC_TIMER0) ? timer0_overflow_i :
                          ext_count_tick;
    wire shift_tick     = (clock_source_i == CLK_SRC_STROBE) ? clock_strobe_i :
                          (clock_source_i == CLK_SRC_TIMER0) ? timer0_overflow_i :
                          ext_shift_tick;
    wire shift_in_bit   = ext_src ? bit_sync : pin_sda;

    // wrap from 15 to 0; with a preset of F one pin edge suffices
    wire wrap           = count_tick & (count == COUNT_MAX);

    // software write wins over a shift in the same cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_reg <= SHIFT_RESET;
        end else if (shift_write_i) begin
            shift_reg <= shift_wdata_i;
        end else if (shift_tick) begin
            shift_reg <= {shift_reg[DATA_W-2:0], shift_in_bit};
        end
    end

    // timer0 overflow as source gives the upper four of twelve bits
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= COUNT_RESET;
        end else if (count_write_i) begin
            count <= count_wdata_i;
        end else if (count_tick) begin
            count <= count + COUNT_ONE;
        end
    end

    // flags: a set in the clearing cycle wins
    wire start_set = two_wire ? ev_start : (ext_src & ~clock_strobe_i & (ev_rise | ev_fall));

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            start_flag <= 1'b0;
            ovf_flag   <= 1'b0;
            stop_flag  <= 1'b0;
        end else begin
            start_flag <= start_set | (start_flag & ~clear_start_i);
            ovf_flag   <= wrap | (ovf_flag & ~clear_overflow_i);
            stop_flag  <= (two_wire & ev_stop) | (stop_flag & ~clear_stop_i);
        end
    end

    // start hold begins at the master's first falling edge after start
    wire next_start_hold = two_wire & start_flag & ~clear_start_i &
                           (start_hold | ev_fall);
    // overflow hold: after eight bits, or after the ack when preset to 14
    wire next_ovf_hold   = ovf_hold_mode & (ovf_flag | wrap) & ~(clear_overflow_i & ~wrap) &
                           (ovf_hold | ev_fall | wrap);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            start_hold <= 1'b0;
            ovf_hold   <= 1'b0;
        end else begin
            start_hold <= next_start_hold;
            ovf_hold   <= next_ovf_hold;
        end
    end

    // toggle strobe flips the clock pin's port bit
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_port <= 1'b1;
        end else if (scl_port_write_i) begin
            scl_port <= scl_port_wdata_i;
        end else if (toggle_strobe_i) begin
            scl_port <= ~scl_port;
        end
    end

    // output latch open while scl is low, so data moves on the falling edge
    wire latch_open = ~ext_src | ~pin_scl;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_latch <= 1'b1;
        end else if (latch_open) begin
            out_latch <= shift_reg[MSB_POS];
        end
    end

    // pin drive; two-wire pins only ever pull low
    logic next_scl_o;
    logic next_scl_oe;
    logic next_sda_o;
    logic next_sda_oe;

    // only a slave's hold logic stretches scl; the master just toggles it
    wire hold_scl = start_hold | ovf_hold;

    always_comb begin
        next_scl_o  = scl_port;
        next_scl_oe = scl_dir_i;
        next_sda_o  = sda_port_i;
        next_sda_oe = sda_dir_i;
        case (wire_mode_i)
            WIRE_NONE: begin
                next_scl_o  = scl_port;
                next_sda_o  = sda_port_i;
            end
            WIRE_THREE: begin
                next_sda_o  = out_latch;
            end
            WIRE_TWO, WIRE_TWO_OVF_HOLD: begin
                next_scl_o  = 1'b0;
                // wait states: scl pulled low while a hold is active
                next_scl_oe = (scl_dir_i & ~scl_port) | hold_scl;
                next_sda_o  = 1'b0;
                // ack, read data or start: sda low from latch or port bit
                next_sda_oe = sda_dir_i & ~(out_latch & sda_port_i);
            end
            default: begin
                next_scl_oe = 1'b0;
                next_sda_oe = 1'b0;
            end
        endcase
    end

    // one clk_i of extra latency on the pins buys glitch-free outputs
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_o    <= 1'b1;
            scl_oe_o <= 1'b0;
            sda_o    <= 1'b1;
            sda_oe_o <= 1'b0;
        end else begin
            scl_o    <= next_scl_o;
            scl_oe_o <= next_scl_oe;
            sda_o    <= next_sda_o;
            sda_oe_o <= next_sda_oe;
        end
    end

    // status outputs; collision only meaningful in two-wire mode
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_data_o        <= SHIFT_RESET;
            count_o             <= COUNT_RESET;
            start_detect_flag_o <= 1'b0;
            overflow_flag_o     <= 1'b0;
            stop_detect_flag_o  <= 1'b0;
            collision_o         <= 1'b0;
        end else begin
            shift_data_o        <= shift_reg;
            count_o             <= count;
            start_detect_flag_o <= start_flag;
            overflow_flag_o     <= ovf_flag;
            stop_detect_flag_o  <= stop_flag;
            collision_o         <= two_wire & (shift_reg[MSB_POS] ^ pin_sda);
        end
    end

endmodule
`default_nettype wire

// ==== verification/bus_master_model.sv ====
// Purpose: two-wire bus master on scl and sda
// Assumes: both lines pulled up; the model only pulls low
// Notes:   half period 600 ns, above the unit's merge limit
`default_nettype none
module bus_master_model #(
    parameter int HALF_NS = 600
) (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output var logic  scl_low_o,
    output var logic  sda_low_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
    // a slave may stretch, so the wait is bounded, never open-ended
    task automatic scl_up(input int tries, output logic ok);
        scl_low_o = 1'b0;
        ok = 1'b0;
        for (int i = 0; i < tries && ok !== 1'b1; i++) begin
            #50;
            ok = scl_i;
        end
    endtask
    task automatic scl_dn();
        scl_low_o = 1'b1;
        #HALF_NS;
    endtask
    task automatic start();
        sda_low_o = 1'b1;
        #HALF_NS;
        scl_dn();
    endtask
    // b low pulls sda, b high leaves sda to the slave
    task automatic bit_cycle(input logic b, output logic seen, output logic ok);
        sda_low_o = ~b;
        #HALF_NS;
        scl_up(40, ok);
        #HALF_NS;
        seen = sda_i;
        scl_dn();
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ok);
        logic seen;
        logic bit_ok;
        ok = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], seen, bit_ok);
            ok = ok & bit_ok;
        end
    endtask
    task automatic stop(output logic ok);
        sda_low_o = 1'b1;
        #HALF_NS;
        scl_up(40, ok);
        #HALF_NS;
        sda_low_o = 1'b0;
        #HALF_NS;
    endtask
endmodule
`default_nettype wire

// ==== verification/universal_serial_unit_tb_top.sv ====
// Purpose: self-checking bench for the serial unit
// Assumes: 20 MHz system clock, 8 MHz free-running link clock
// Notes:   inputs change 5 ns after clk rises
`default_nettype none
module universal_serial_unit_tb_top;
    import serial_unit_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, link_clk, rstn, clock_strobe, timer0_ovf, shift_write, count_write;
    logic       clear_start, clear_overflow, clear_stop, scl_dir, sda_dir, scl_low, sda_low;
    logic       start_flag, ovf_flag, stop_flag, scl_o, scl_oe, sda_o, sda_oe, ok, seen, toggle, collision;
    logic [1:0] wire_mode, clock_source;
    logic [7:0] shift_wdata, shift_data;
    logic [3:0] count_wdata, count;
    wire        scl = ~(scl_low | (scl_oe & ~scl_o));
    wire        sda = ~(sda_low | (sda_oe & ~sda_o));
    int         fail_count = 0;
    int         num_checks = 0;
    universal_serial_unit DUT (
        .clk_i(clk), .rstn_i(rstn), .link_clk_i(link_clk), .wire_mode_i(wire_mode),
        .clock_source_i(clock_source), .clock_strobe_i(clock_strobe), .toggle_strobe_i(toggle),
        .timer0_overflow_i(timer0_ovf), .shift_write_i(shift_write), .shift_wdata_i(shift_wdata),
        .count_write_i(count_write), .count_wdata_i(count_wdata), .clear_start_i(clear_start),
        .clear_overflow_i(clear_overflow), .clear_stop_i(clear_stop), .scl_dir_i(scl_dir),
        .sda_dir_i(sda_dir), .sda_port_i(1'b1), .scl_port_write_i(1'b0), .scl_port_wdata_i(1'b0),
        .scl_i(scl), .sda_i(sda), .shift_data_o(shift_data), .count_o(count),
        .start_detect_flag_o(start_flag), .overflow_flag_o(ovf_flag), .stop_detect_flag_o(stop_flag),
        .collision_o(collision), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_o(sda_o), .sda_oe_o(sda_oe)
    );
    bus_master_model mst (.scl_i(scl), .sda_i(sda), .scl_low_o(scl_low), .sda_low_o(sda_low));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #37;
        forever #62.5 link_clk = ~link_clk;
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    // counter load and flag clears in one cycle, then let outputs settle
    task automatic sw(input logic wc, input logic [3:0] cnt, input logic [2:0] clr);
        count_write = wc;
        count_wdata = cnt;
        {clear_start, clear_overflow, clear_stop} = clr;
        tick();
        count_write = 1'b0;
        {clear_start, clear_overflow, clear_stop} = 3'b000;
        tick(4);
    endtask
    task automatic pulses(input logic tmr, input int n);
        repeat (n) begin
            timer0_ovf = tmr;
            clock_strobe = ~tmr;
            tick();
            timer0_ovf = 1'b0;
            clock_strobe = 1'b0;
            tick();
        end
        tick(2);
    endtask
    task automatic wr_shift(input logic [7:0] d);
        shift_write = 1'b1;
        shift_wdata = d;
        tick();
        shift_write = 1'b0;
        tick(3);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {rstn, clock_strobe, timer0_ovf, shift_write, count_write, scl_dir, sda_dir, toggle} = '0;
        {clear_start, clear_overflow, clear_stop, shift_wdata, count_wdata} = '0;
        wire_mode = WIRE_NONE;
        clock_source = CLK_SRC_STROBE;
        tick(2);
        rstn = 1'b1;
        tick(4);
        check("reset state", {count, start_flag, ovf_flag, stop_flag, scl_oe}, 8'h00);
        for (int i = 0; i < 2; i++) begin
            toggle = 1'b1;
            tick();
            toggle = 1'b0;
            tick(2);
            check("scl toggle", {7'h0, scl_o}, 8'(i));
        end
        sw(1'b1, 4'hd, 3'b000);
        pulses(1'b0, 2);
        check("strobe count", {4'h0, count}, 8'h0f);
        pulses(1'b0, 1);
        check("wrap", {3'h0, ovf_flag, count}, 8'h10);
        sw(1'b0, 4'h0, 3'b010);
        check("ovf clear", {7'h0, ovf_flag}, 8'h00);
        wr_shift(8'h5a);
        check("shift load", shift_data, 8'h5a);
        pulses(1'b0, 1);
        check("shift step", shift_data, 8'hb5);
        clock_source = CLK_SRC_TIMER0;
        sw(1'b1, 4'h0, 3'b000);
        pulses(1'b1, 16);
        check("chained wrap", {3'h0, ovf_flag, count}, 8'h10);
        clock_source = CLK_SRC_EXT_POS;
        sw(1'b1, 4'h0, 3'b010);
        mst.scl_dn();
        mst.scl_up(40, ok);
        tick(12);
        check("both edges", {2'h0, ok, ovf_flag, count}, 8'h22);
        sw(1'b1, 4'hf, 3'b101);
        mst.scl_dn();
        tick(12);
        check("edge irq", {3'h0, ovf_flag, count}, 8'h10);
        mst.scl_up(40, ok);
        tick(12);
        sw(1'b0, 4'h0, 3'b111);
        wire_mode = WIRE_TWO_OVF_HOLD;
        clock_source = CLK_SRC_EXT_NEG;
        scl_dir = 1'b1;
        tick(12);
        mst.start();
        tick(12);
        check("start hold", {6'h0, start_flag, scl_oe & ~scl_o}, 8'h03);
        mst.scl_up(20, ok);
        check("stretched", {7'h0, ok}, 8'h00);
        mst.scl_dn();
        sw(1'b1, 4'h0, 3'b100);
        check("start release", {6'h0, start_flag, scl_oe}, 8'h00);
        mst.send_byte(8'ha5, ok);
        tick(12);
        check("address", shift_data, 8'ha5);
        check("byte hold", {2'h0, ok, ovf_flag, scl_oe & ~scl_o, count[2:0]}, 8'h38);
        wr_shift(8'h00);
        check("collision", {7'h0, collision}, 8'h01);
        sda_dir = 1'b1;
        sw(1'b1, 4'he, 3'b010);
        mst.bit_cycle(1'b1, seen, ok);
        tick(12);
        check("ack", {5'h0, ok, seen, ovf_flag}, 8'h05);
        sda_dir = 1'b0;
        sw(1'b1, 4'h0, 3'b010);
        mst.send_byte(8'h3c, ok);
        tick(12);
        check("data byte", shift_data, 8'h3c);
        wr_shift(8'hff);
        sda_dir = 1'b1;
        sw(1'b1, 4'he, 3'b010);
        mst.bit_cycle(1'b1, seen, ok);
        tick(12);
        check("nack", {6'h0, ok, seen}, 8'h03);
        sda_dir = 1'b0;
        sw(1'b0, 4'h0, 3'b010);
        mst.stop(ok);
        tick(12);
        check("stop", {6'h0, ok, stop_flag}, 8'h03);
        sw(1'b1, 4'h7, 3'b001);
        check("stop clear", {7'h0, stop_flag}, 8'h00);
        rstn = 1'b0;
        tick(6);
        rstn = 1'b1;
        tick(4);
        check("mid reset", {count, start_flag, ovf_flag, stop_flag, scl_oe}, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire

// ==== verification/usu_chk.sv ====
// Purpose: port checker for the serial unit
// Assumes: outputs lag a request by two clk_i edges
// Notes:   bound to every instance of the unit
`default_nettype none
module usu_chk
    import serial_unit_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rstn_i,
    input wire logic [1:0]        wire_mode_i,
    input wire logic [1:0]        clock_source_i,
    input wire logic              clock_strobe_i,
    input wire logic              timer0_overflow_i,
    input wire logic              shift_write_i,
    input wire logic [DATA_W-1:0] shift_wdata_i,
    input wire logic              count_write_i,
    input wire logic [COUNT_W-1:0] count_wdata_i,
    input wire logic              clear_start_i,
    input wire logic              clear_overflow_i,
    input wire logic              clear_stop_i,
    input wire logic              scl_dir_i,
    input wire logic [DATA_W-1:0] shift_data_o,
    input wire logic [COUNT_W-1:0] count_o,
    input wire logic              start_detect_flag_o,
    input wire logic              overflow_flag_o,
    input wire logic              stop_detect_flag_o,
    input wire logic              scl_o,
    input wire logic              scl_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    count_load_a: assert property (count_write_i |-> ##2 count_o == $past(count_wdata_i, 2))
        else $error("counter load not seen");
    shift_load_a: assert property (shift_write_i |-> ##2 shift_data_o == $past(shift_wdata_i, 2))
        else $error("shift load not seen");
    strobe_count_a: assert property ((clock_source_i == CLK_SRC_STROBE && clock_strobe_i && !count_write_i)
        |=> ##1 count_o == $past(count_o) + 4'h1) else $error("strobe did not count");
    timer_count_a: assert property ((clock_source_i == CLK_SRC_TIMER0 && timer0_overflow_i && !count_write_i)
        |=> ##1 count_o == $past(count_o) + 4'h1) else $error("timer overflow did not count");
    ovf_set_a: assert property ((count_o == 4'hf && !$past(count_write_i)) ##1 count_o == 4'h0
        |-> overflow_flag_o) else $error("wrap without overflow flag");
    ovf_clear_a: assert property ($fell(overflow_flag_o) |-> $past(clear_overflow_i, 2))
        else $error("overflow flag fell unasked");
    start_clear_a: assert property ($fell(start_detect_flag_o) |-> $past(clear_start_i, 2))
        else $error("start flag fell unasked");
    stop_clear_a: assert property ($fell(stop_detect_flag_o) |-> $past(clear_stop_i, 2))
        else $error("stop flag fell unasked");
    ovf_hold_a: assert property (($rose(overflow_flag_o) && wire_mode_i == WIRE_TWO_OVF_HOLD && scl_dir_i)
        |-> ##[0:2] (scl_oe_o && !scl_o)) else $error("scl not held on overflow");
endmodule
bind universal_serial_unit usu_chk chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .wire_mode_i(wire_mode_i), .clock_source_i(clock_source_i),
    .clock_strobe_i(clock_strobe_i), .timer0_overflow_i(timer0_overflow_i), .shift_write_i(shift_write_i),
    .shift_wdata_i(shift_wdata_i), .count_write_i(count_write_i), .count_wdata_i(count_wdata_i),
    .clear_start_i(clear_start_i), .clear_overflow_i(clear_overflow_i), .clear_stop_i(clear_stop_i),
    .scl_dir_i(scl_dir_i), .shift_data_o(shift_data_o), .count_o(count_o),
    .start_detect_flag_o(start_detect_flag_o), .overflow_flag_o(overflow_flag_o),
    .stop_detect_flag_o(stop_detect_flag_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o)
);
`default_nettype wire
